// file: hdl/qbt_fifo2.sv
// two-entry buffer for driver data words
// assumes asynchronous active-low reset copy and a common clock enable
`timescale 1ns/100ps
`default_nettype none
`include "qbt_params.svh"

module qbt_fifo2
  import qbt_pkg::*;
(
  input  wire logic  i_clk,
  input  wire logic  i_clk_en,
  input  wire logic  i_rst_n,
  qbt_stream_if.snk  s_in,
  qbt_stream_if.src  s_out
);

  logic [1:0] count;
  logic [1:0] next_count;
  logic       wr_ptr;
  logic       next_wr_ptr;
  logic       rd_ptr;
  logic       next_rd_ptr;
  qbt_nib_t   mem      [2];
  qbt_nib_t   next_mem [2];
  logic       push;
  logic       pop;

  assign s_in.ready  = (count != `QBT_FIFO_DEPTH);
  assign s_out.valid = (count != 2'h0);
  assign s_out.data  = mem[rd_ptr];
  assign push        = s_in.valid & s_in.ready;
  assign pop         = s_out.valid & s_out.ready;

  always_comb begin
    next_count  = count;
    next_wr_ptr = wr_ptr;
    next_rd_ptr = rd_ptr;
    if (push) begin
      next_wr_ptr = ~wr_ptr;
    end
    if (pop) begin
      next_rd_ptr = ~rd_ptr;
    end
    if (push && !pop) begin
      next_count = count + 2'h1;
    end else if (pop && !push) begin
      next_count = count - 2'h1;
    end
  end

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_entry
      assign next_mem[g] = (push && (wr_ptr == 1'(g))) ? s_in.data : mem[g];
    end
  endgenerate

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      count  <= 2'h0;
      wr_ptr <= 1'b0;
      rd_ptr <= 1'b0;
    end else if (i_clk_en) begin
      count  <= next_count;
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
    end
  end

  // storage needs no reset, empty entries are never read out as valid
  always_ff @(posedge i_clk) begin
    if (i_clk_en) begin
      mem <= next_mem;
    end
  end

endmodule : qbt_fifo2

`default_nettype wire

// file: hdl/qbt_params.svh
// constants of the quad bus transceiver: register map, fields, resets
// assumes a 32-bit axi4-lite slave with byte addresses
`ifndef QBT_PARAMS_SVH
`define QBT_PARAMS_SVH

`define QBT_ADDR_W        8
`define QBT_CTRL_OFS      8'h00
`define QBT_TXDATA_OFS    8'h04
`define QBT_STATUS_OFS    8'h08

`define QBT_CTRL_BE_BIT   0
`define QBT_CTRL_RLE_BIT  1
`define QBT_CTRL_OE_BIT   2
`define QBT_CTRL_W        3
`define QBT_CTRL_RST      3'h7

`define QBT_ST_DRV_LSB    0
`define QBT_ST_RCV_LSB    4
`define QBT_ST_PAR_BIT    8
`define QBT_ST_FULL_BIT   9
`define QBT_ST_EMPTY_BIT  10
`define QBT_ST_A_LSB      12

`define QBT_RESP_OKAY     2'h0
`define QBT_RESP_SLVERR   2'h2

`define QBT_FIFO_DEPTH    2'h2

`endif

// file: hdl/qbt_pkg.sv
// types of the quad bus transceiver
// assumes qbt_params.svh holds the numeric constants
package qbt_pkg;

  typedef logic [3:0] qbt_nib_t;

  typedef enum logic [2:0] {
    QBT_WR_IDLE = 3'b001,
    QBT_WR_PUSH = 3'b010,
    QBT_WR_RESP = 3'b100
  } qbt_wr_state_t;

endpackage : qbt_pkg

// file: hdl/qbt_stream_if.sv
// valid/ready carrier for one 4-bit data word
// assumes both ends share one clock
`timescale 1ns/100ps
`default_nettype none

interface qbt_stream_if;
  import qbt_pkg::*;
  logic     valid;
  logic     ready;
  qbt_nib_t data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface : qbt_stream_if

`default_nettype wire

// file: hdl/qbt_transceiver.sv
// quad bus transceiver with parity, registers on axi4-lite
// assumes bus and driver clock pins are asynchronous to i_ref_clk
// Functional notes
// - bus drive enable high floats all four bus drivers; low drives them
// - output enable high floats receiver outputs; low shows latched data
// - receiver outputs present the inverse of the bus lines
// - latch enable low makes latches follow the bus continuously
// - latch enable high holds the latch contents regardless of anything
// - rising driver clock captures the four data inputs into the register
// - without a rising driver clock edge the register keeps its value
// - enabled drivers put the inverse of the register bits on the bus
// - driving: parity output is xor of the four data inputs
// - not driving: parity output is xor of the four latch contents
//
// Design decisions made here: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
`default_nettype none
`include "qbt_params.svh"

module qbt_transceiver
  import qbt_pkg::*;
(
  input  wire logic                   i_ref_clk,
  input  wire logic                   i_arst_n,
  input  wire logic                   i_clk_en,
  input  wire logic [`QBT_ADDR_W-1:0] i_axi_awaddr,
  input  wire logic                   i_axi_awvalid,
  output logic                        o_axi_awready,
  input  wire logic [31:0]            i_axi_wdata,
  input  wire logic [3:0]             i_axi_wstrb,
  input  wire logic                   i_axi_wvalid,
  output logic                        o_axi_wready,
  output logic [1:0]                  o_axi_bresp,
  output logic                        o_axi_bvalid,
  input  wire logic                   i_axi_bready,
  input  wire logic [`QBT_ADDR_W-1:0] i_axi_araddr,
  input  wire logic                   i_axi_arvalid,
  output logic                        o_axi_arready,
  output logic [31:0]                 o_axi_rdata,
  output logic [1:0]                  o_axi_rresp,
  output logic                        o_axi_rvalid,
  input  wire logic                   i_axi_rready,
  input  wire logic                   i_driver_clock,
  input  wire logic [3:0]             i_bus,
  output logic [3:0]                  o_bus,
  output logic [3:0]                  o_bus_oe_n,
  output logic [3:0]                  o_rcv,
  output logic [3:0]                  o_rcv_oe_n,
  output logic                        o_odd_parity
);

  // reset release
  logic rst_s1;
  logic rst_n;

  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rst_s1 <= 1'b0;
      rst_n  <= 1'b0;
    end else begin
      rst_s1 <= 1'b1;
      rst_n  <= rst_s1;
    end
  end

  // pin synchronisers, a change counts once stages two and three agree
  qbt_nib_t bus_s1;
  qbt_nib_t bus_s2;
  qbt_nib_t bus_s3;
  qbt_nib_t bus_filt;
  qbt_nib_t next_bus_filt;
  logic     dclk_s1;
  logic     dclk_s2;
  logic     dclk_s3;
  logic     dclk_filt;
  logic     next_dclk_filt;
  logic     drv_rise;

  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_bus_bit
      assign next_bus_filt[g] = (bus_s2[g] == bus_s3[g]) ? bus_s3[g]
                                                         : bus_filt[g];
    end
  endgenerate

  assign next_dclk_filt = (dclk_s2 == dclk_s3) ? dclk_s3 : dclk_filt;
  // edge seen only by the filtered level, so a glitch cannot load twice
  assign drv_rise       = next_dclk_filt & ~dclk_filt;

  always_ff @(posedge i_ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      bus_s1    <= 4'h0;
      bus_s2    <= 4'h0;
      bus_s3    <= 4'h0;
      bus_filt  <= 4'h0;
      dclk_s1   <= 1'b0;
      dclk_s2   <= 1'b0;
      dclk_s3   <= 1'b0;
      dclk_filt <= 1'b0;
    end else if (i_clk_en) begin
      bus_s1    <= i_bus;
      bus_s2    <= bus_s1;
      bus_s3    <= bus_s2;
      bus_filt  <= next_bus_filt;
      dclk_s1   <= i_driver_clock;
      dclk_s2   <= dclk_s1;
      dclk_s3   <= dclk_s2;
      dclk_filt <= next_dclk_filt;
    end
  end

  // control register and driver data buffer
  logic [`QBT_CTRL_W-1:0] ctrl;
  logic [`QBT_CTRL_W-1:0] next_ctrl;
  logic                   bus_drive_enable_n;
  logic                   receive_latch_enable_n;
  logic                   output_enable_n;

  assign bus_drive_enable_n     = ctrl[`QBT_CTRL_BE_BIT];
  assign receive_latch_enable_n = ctrl[`QBT_CTRL_RLE_BIT];
  assign output_enable_n        = ctrl[`QBT_CTRL_OE_BIT];

  qbt_stream_if push_if ();
  qbt_stream_if tx_if ();

  qbt_fifo2 u_txbuf (
    .i_clk    (i_ref_clk),
    .i_clk_en (i_clk_en),
    .i_rst_n  (rst_n),
    .s_in     (push_if),
    .s_out    (tx_if)
  );

  // data inputs: the buffer head, or the last word once it drains
  qbt_nib_t a_hold;
  qbt_nib_t next_a_hold;
  qbt_nib_t a_data;

  assign a_data      = tx_if.valid ? tx_if.data : a_hold;
  assign tx_if.ready = drv_rise & i_clk_en;
  assign next_a_hold = (tx_if.valid & tx_if.ready) ? tx_if.data : a_hold;

  // driver register, receive latches, parity
  qbt_nib_t drv_reg;
  qbt_nib_t next_drv_reg;
  qbt_nib_t rcv_latch;
  qbt_nib_t next_rcv_latch;
  logic     par;
  logic     next_par;

  always_comb begin
    next_drv_reg   = drv_rise ? a_data : drv_reg;
    next_rcv_latch = receive_latch_enable_n ? rcv_latch
                                            : bus_filt;
    next_par       = bus_drive_enable_n ? ^rcv_latch
                                        : ^a_data;
  end

  // no reset here, contents are unknown until loaded
  always_ff @(posedge i_ref_clk) begin
    if (i_clk_en) begin
      drv_reg   <= next_drv_reg;
      rcv_latch <= next_rcv_latch;
    end
  end

  always_ff @(posedge i_ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      par    <= 1'b0;
      a_hold <= 4'h0;
    end else if (i_clk_en) begin
      par    <= next_par;
      a_hold <= next_a_hold;
    end
  end

  assign o_bus        = ~drv_reg;
  assign o_bus_oe_n   = {4{bus_drive_enable_n}};
  assign o_rcv        = ~rcv_latch;
  assign o_rcv_oe_n   = {4{output_enable_n}};
  assign o_odd_parity = par;

  // axi4-lite write side
  qbt_wr_state_t          wr_state;
  qbt_wr_state_t          next_wr_state;
  logic                   aw_held;
  logic                   next_aw_held;
  logic                   w_held;
  logic                   next_w_held;
  logic [`QBT_ADDR_W-1:0] aw_addr;
  logic [`QBT_ADDR_W-1:0] next_aw_addr;
  logic [31:0]            w_data;
  logic [31:0]            next_w_data;
  logic                   w_lane0;
  logic                   next_w_lane0;
  logic [1:0]             bresp;
  logic [1:0]             next_bresp;

  assign o_axi_awready = i_clk_en & (wr_state == QBT_WR_IDLE) & ~aw_held;
  assign o_axi_wready  = i_clk_en & (wr_state == QBT_WR_IDLE) & ~w_held;
  assign o_axi_bvalid  = (wr_state == QBT_WR_RESP);
  assign o_axi_bresp   = bresp;
  assign push_if.valid = (wr_state == QBT_WR_PUSH);
  assign push_if.data  = w_data[3:0];

  always_comb begin
    next_wr_state = wr_state;
    next_aw_held  = aw_held;
    next_w_held   = w_held;
    next_aw_addr  = aw_addr;
    next_w_data   = w_data;
    next_w_lane0  = w_lane0;
    next_bresp    = bresp;
    next_ctrl     = ctrl;
    if (i_axi_awvalid && o_axi_awready) begin
      next_aw_held = 1'b1;
      next_aw_addr = i_axi_awaddr;
    end
    if (i_axi_wvalid && o_axi_wready) begin
      next_w_held  = 1'b1;
      next_w_data  = i_axi_wdata;
      next_w_lane0 = i_axi_wstrb[0];
    end
    unique case (wr_state)
      QBT_WR_IDLE: begin
        if (aw_held && w_held) begin
          next_bresp    = `QBT_RESP_OKAY;
          next_wr_state = QBT_WR_RESP;
          if (aw_addr == `QBT_CTRL_OFS) begin
            if (w_lane0) begin
              next_ctrl = w_data[`QBT_CTRL_W-1:0];
            end
          end else if (aw_addr == `QBT_TXDATA_OFS) begin
            if (w_lane0) begin
              next_wr_state = QBT_WR_PUSH;
            end
          end else if (aw_addr != `QBT_STATUS_OFS) begin
            next_bresp = `QBT_RESP_SLVERR;
          end
        end
      end
      // a full buffer holds the word in w_data and stalls the write response until it is pushed
      QBT_WR_PUSH: begin
        if (push_if.ready) begin
          next_wr_state = QBT_WR_RESP;
        end
      end
      QBT_WR_RESP: begin
        if (i_axi_bready) begin
          next_wr_state = QBT_WR_IDLE;
          next_aw_held  = 1'b0;
          next_w_held   = 1'b0;
        end
      end
      default: begin
        next_wr_state = QBT_WR_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_state <= QBT_WR_IDLE;
      aw_held  <= 1'b0;
      w_held   <= 1'b0;
      aw_addr  <= 8'h00;
      w_data   <= 32'h0000_0000;
      w_lane0  <= 1'b0;
      bresp    <= `QBT_RESP_OKAY;
      ctrl     <= `QBT_CTRL_RST;
    end else if (i_clk_en) begin
      wr_state <= next_wr_state;
      aw_held  <= next_aw_held;
      w_held   <= next_w_held;
      aw_addr  <= next_aw_addr;
      w_data   <= next_w_data;
      w_lane0  <= next_w_lane0;
      bresp    <= next_bresp;
      ctrl     <= next_ctrl;
    end
  end

  // axi4-lite read side, answer one cycle after the address is taken
  logic        rvalid;
  logic        next_rvalid;
  logic [31:0] rdata;
  logic [31:0] next_rdata;
  logic [1:0]  rresp;
  logic [1:0]  next_rresp;
  logic [31:0] status_word;

  always_comb begin
    status_word = 32'h0000_0000;
    status_word[`QBT_ST_DRV_LSB +: 4] = drv_reg;
    status_word[`QBT_ST_RCV_LSB +: 4] = o_rcv;
    status_word[`QBT_ST_PAR_BIT]      = par;
    status_word[`QBT_ST_FULL_BIT]     = ~push_if.ready;
    status_word[`QBT_ST_EMPTY_BIT]    = ~tx_if.valid;
    status_word[`QBT_ST_A_LSB +: 4]   = a_data;
  end

  assign o_axi_arready = i_clk_en & ~rvalid;
  assign o_axi_rvalid  = rvalid;
  assign o_axi_rdata   = rdata;
  assign o_axi_rresp   = rresp;

  always_comb begin
    next_rvalid = rvalid;
    next_rdata  = rdata;
    next_rresp  = rresp;
    if (rvalid && i_axi_rready) begin
      next_rvalid = 1'b0;
    end
    if (i_axi_arvalid && o_axi_arready) begin
      next_rvalid = 1'b1;
      next_rresp  = `QBT_RESP_OKAY;
      next_rdata  = 32'h0000_0000;
      if (i_axi_araddr == `QBT_CTRL_OFS) begin
        next_rdata[`QBT_CTRL_W-1:0] = ctrl;
      end else if (i_axi_araddr == `QBT_TXDATA_OFS) begin
        next_rdata[3:0] = a_data;
      end else if (i_axi_araddr == `QBT_STATUS_OFS) begin
        next_rdata = status_word;
      end else begin
        next_rresp = `QBT_RESP_SLVERR;
      end
    end
  end

  always_ff @(posedge i_ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rvalid <= 1'b0;
      rdata  <= 32'h0000_0000;
      rresp  <= `QBT_RESP_OKAY;
    end else if (i_clk_en) begin
      rvalid <= next_rvalid;
      rdata  <= next_rdata;
      rresp  <= next_rresp;
    end
  end

  // checks
  chk_bus_float_drive:
  assert property (@(posedge i_ref_clk) disable iff (!rst_n)
    ctrl[`QBT_CTRL_BE_BIT] |-> (o_bus_oe_n == 4'hf))
    else $error("bus drivers not floated while bus enable high");

  chk_bus_oe_follow:
  assert property (@(posedge i_ref_clk) disable iff (!rst_n)
    (i_clk_en && (wr_state == QBT_WR_IDLE) && aw_held && w_held && w_lane0
     && (aw_addr == `QBT_CTRL_OFS))
    |=> (o_bus_oe_n == {4{$past(w_data[`QBT_CTRL_BE_BIT])}}))
    else $error("bus drivers do not follow control write");

  chk_rcv_oe_follow:
  assert property (@(posedge i_ref_clk) disable iff (!rst_n)
    (i_clk_en && (wr_state == QBT_WR_IDLE) && aw_held && w_held && w_lane0
     && (aw_addr == `QBT_CTRL_OFS))
    |=> (o_rcv_oe_n == {4{$past(w_data[`QBT_CTRL_OE_BIT])}}))
    else $error("receiver enable does not follow control write");

  chk_rcv_inverted:
  assert property (@(posedge i_ref_clk) disable iff (!rst_n)
    (i_clk_en && !receive_latch_enable_n) |=> (o_rcv == ~$past(bus_filt)))
    else $error("receiver output is not the inverted bus");

  chk_latch_open_follow:
  assert property (@(posedge i_ref_clk) disable iff (!rst_n)
    (i_clk_en && !receive_latch_enable_n)
    |=> (rcv_latch == $past(bus_filt)))
    else $error("open latch does not follow bus");

  chk_latch_closed_hold:
  assert property (@(posedge i_ref_clk) disable iff (!rst_n)
    receive_latch_enable_n |=> $stable(rcv_latch))
    else $error("closed latch changed");

  chk_drv_load_edge:
  assert property (@(posedge i_ref_clk) disable iff (!rst_n)
    (i_clk_en && drv_rise) |=> (drv_reg == $past(a_data)))
    else $error("driver register missed rising driver clock");

  chk_drv_hold_no_edge:
  assert property (@(posedge i_ref_clk) disable iff (!rst_n)
    !(i_clk_en && drv_rise) |=> $stable(drv_reg))
    else $error("driver register changed without rising edge");

  // case equality: the register is unloaded after power-up and both sides
  // then carry the same unknown
  chk_bus_drive_inv:
  assert property (@(posedge i_ref_clk) disable iff (!rst_n)
    !ctrl[`QBT_CTRL_BE_BIT] |-> ((o_bus_oe_n == 4'h0) && (o_bus === ~drv_reg)))
    else $error("enabled bus does not carry inverted register");

  chk_par_generate:
  assert property (@(posedge i_ref_clk) disable iff (!rst_n)
    (i_clk_en && !bus_drive_enable_n) |=> (o_odd_parity == ^$past(a_data)))
    else $error("generated parity wrong");

  chk_par_check:
  assert property (@(posedge i_ref_clk) disable iff (!rst_n)
    (i_clk_en && bus_drive_enable_n) |=> (o_odd_parity === ^$past(rcv_latch)))
    else $error("checked parity wrong");

endmodule : qbt_transceiver

`default_nettype wire

// file: verif/qbt_bus_partner.sv
// model of the shared four-line bus beyond the transceiver
// assumes the bench picks when the far side drives and what it drives
`timescale 1ns/100ps
`default_nettype none

module qbt_bus_partner
  import qbt_pkg::*;
(
  input  wire logic     i_clk,
  input  wire logic     i_drive,
  input  wire qbt_nib_t i_val,
  input  wire qbt_nib_t i_dut_val,
  input  wire qbt_nib_t i_dut_oe_n,
  output var  qbt_nib_t o_wire
);
  // undriven lines flip each cycle, so a stale level never looks valid
  qbt_nib_t float_q = 4'h5;

  always_ff @(posedge i_clk) begin
    float_q <= ~float_q;
  end

  always_comb begin
    for (int i = 0; i < 4; i++) begin
      if (!i_dut_oe_n[i]) begin
        o_wire[i] = i_dut_val[i];
      end else if (i_drive) begin
        o_wire[i] = i_val[i];
      end else begin
        o_wire[i] = float_q[i];
      end
    end
  end
endmodule : qbt_bus_partner

`default_nettype wire

// file: verif/tb_quad_bus_transceiver_parity.sv
// self-checking bench: registers over axi4-lite, driver and receive paths
// assumes the bus partner model resolves the four bus lines
`timescale 1ns/100ps
`default_nettype none
`include "qbt_params.svh"

module tb_quad_bus_transceiver_parity;
  import qbt_pkg::*;
  logic        clk = 1'b0;
  logic        arst_n = 1'b0;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic        arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [3:0]  wstrb = 4'h0;
  logic        awready, wready, bvalid, arready, rvalid, par;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata;
  logic        dclk = 1'b0;
  logic        p_drive = 1'b0;
  qbt_nib_t    p_val = 4'h0;
  qbt_nib_t    bus_w, bus_o, bus_oe_n, rcv, rcv_oe_n;
  int          error_cnt = 0;
  int          checked = 0;
  logic [1:0]  resp;
  logic [31:0] rd;

  always #20 clk = ~clk;

  qbt_transceiver dut (
    .i_ref_clk(clk), .i_arst_n(arst_n), .i_clk_en(1'b1),
    .i_axi_awaddr(awaddr), .i_axi_awvalid(awvalid),
    .o_axi_awready(awready), .i_axi_wdata(wdata), .i_axi_wstrb(wstrb),
    .i_axi_wvalid(wvalid), .o_axi_wready(wready), .o_axi_bresp(bresp),
    .o_axi_bvalid(bvalid), .i_axi_bready(bready), .i_axi_araddr(araddr),
    .i_axi_arvalid(arvalid), .o_axi_arready(arready), .o_axi_rdata(rdata),
    .o_axi_rresp(rresp), .o_axi_rvalid(rvalid), .i_axi_rready(rready),
    .i_driver_clock(dclk), .i_bus(bus_w), .o_bus(bus_o),
    .o_bus_oe_n(bus_oe_n), .o_rcv(rcv), .o_rcv_oe_n(rcv_oe_n),
    .o_odd_parity(par)
  );

  qbt_bus_partner partner (
    .i_clk(clk), .i_drive(p_drive), .i_val(p_val), .i_dut_val(bus_o),
    .i_dut_oe_n(bus_oe_n), .o_wire(bus_w)
  );

  task automatic end_sim();
    if (error_cnt == 0 && checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : end_sim

  task automatic chk(input string name, input logic [31:0] exp,
                     input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  // readies sampled mid-cycle, so each handshake uses its pre-edge value
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
                        input logic [3:0] s, output logic [1:0] r);
    logic aw_r, w_r, b_v;
    @(posedge clk);
    awaddr <= a; wdata <= d; wstrb <= s;
    awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    forever begin
      @(negedge clk);
      aw_r = awready; w_r = wready; b_v = bvalid;
      @(posedge clk);
      if (awvalid && aw_r) awvalid <= 1'b0;
      if (wvalid && w_r) wvalid <= 1'b0;
      if (b_v) begin
        r = bresp;
        bready <= 1'b0;
        break;
      end
    end
  endtask : axi_wr

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d,
                        output logic [1:0] r);
    logic ar_r, r_v;
    @(posedge clk);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    forever begin
      @(negedge clk);
      ar_r = arready; r_v = rvalid;
      d = rdata; r = rresp;
      @(posedge clk);
      if (arvalid && ar_r) arvalid <= 1'b0;
      if (r_v) begin
        rready <= 1'b0;
        break;
      end
    end
  endtask : axi_rd

  task automatic set_ctrl(input logic [2:0] v);
    axi_wr(`QBT_CTRL_OFS, {29'h0, v}, 4'hf, resp);
    repeat (4) @(posedge clk);
  endtask : set_ctrl

  task automatic push(input qbt_nib_t v);
    axi_wr(`QBT_TXDATA_OFS, {28'h0, v}, 4'h1, resp);
    chk("push bresp", 32'(`QBT_RESP_OKAY), 32'(resp));
  endtask : push

  // pin edge crosses a synchroniser, so give it room on both levels
  task automatic drv_pulse();
    @(posedge clk);
    dclk <= 1'b1;
    repeat (6) @(posedge clk);
    dclk <= 1'b0;
    repeat (8) @(posedge clk);
  endtask : drv_pulse

  task automatic t_regs();
    axi_rd(`QBT_CTRL_OFS, rd, resp);
    chk("ctrl reset", 32'(`QBT_CTRL_RST), {29'h0, rd[2:0]});
    chk("bus oe reset", 32'hf, 32'(bus_oe_n));
    chk("rcv oe reset", 32'hf, 32'(rcv_oe_n));
    axi_wr(`QBT_CTRL_OFS, 32'h0, 4'h0, resp);
    axi_rd(`QBT_CTRL_OFS, rd, resp);
    chk("ctrl no strobe", 32'(`QBT_CTRL_RST), {29'h0, rd[2:0]});
    axi_wr(8'h10, 32'h0, 4'hf, resp);
    chk("wr unmapped", 32'(`QBT_RESP_SLVERR), 32'(resp));
    axi_rd(8'h10, rd, resp);
    chk("rd unmapped", 32'(`QBT_RESP_SLVERR), 32'(resp));
    axi_wr(`QBT_STATUS_OFS, 32'h0, 4'hf, resp);
    chk("wr status", 32'(`QBT_RESP_OKAY), 32'(resp));
  endtask : t_regs

  task automatic t_drive();
    set_ctrl(3'h6);
    chk("bus oe drive", 32'h0, 32'(bus_oe_n));
    push(4'h5);
    drv_pulse();
    chk("bus drive 5", 32'ha, 32'(bus_o));
    chk("parity gen 5", 32'h0, 32'(par));
    push(4'h7);
    repeat (20) @(posedge clk);
    chk("bus held", 32'ha, 32'(bus_o));
    chk("parity gen 7", 32'h1, 32'(par));
    drv_pulse();
    chk("bus drive 7", 32'h8, 32'(bus_o));
  endtask : t_drive

  task automatic t_buffer();
    push(4'h1);
    push(4'h2);
    axi_rd(`QBT_STATUS_OFS, rd, resp);
    chk("buf full", 32'h1, 32'(rd[`QBT_ST_FULL_BIT]));
    drv_pulse();
    chk("bus drive 1", 32'he, 32'(bus_o));
    drv_pulse();
    axi_rd(`QBT_STATUS_OFS, rd, resp);
    chk("buf empty", 32'h1, 32'(rd[`QBT_ST_EMPTY_BIT]));
    chk("drv reg", 32'h2, 32'(rd[3:0]));
  endtask : t_buffer

  task automatic t_receive();
    @(posedge clk);
    p_drive <= 1'b1;
    p_val <= 4'h7;
    set_ctrl(3'h1);
    repeat (10) @(posedge clk);
    chk("bus oe float", 32'hf, 32'(bus_oe_n));
    chk("rcv oe on", 32'h0, 32'(rcv_oe_n));
    chk("rcv open", 32'h8, 32'(rcv));
    chk("parity chk", 32'h1, 32'(par));
    set_ctrl(3'h3);
    @(posedge clk);
    p_val <= 4'h0;
    repeat (12) @(posedge clk);
    chk("rcv held", 32'h8, 32'(rcv));
    chk("parity held", 32'h1, 32'(par));
    set_ctrl(3'h1);
    repeat (10) @(posedge clk);
    chk("rcv follow", 32'hf, 32'(rcv));
    chk("parity zero", 32'h0, 32'(par));
    set_ctrl(3'h5);
    chk("rcv oe off", 32'hf, 32'(rcv_oe_n));
  endtask : t_receive

  initial begin
    #(40 * 20000);
    error_cnt++;
    end_sim();
  end

  initial begin
    repeat (12) @(posedge clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge clk);
    t_regs();
    t_drive();
    t_buffer();
    t_receive();
    end_sim();
  end
endmodule : tb_quad_bus_transceiver_parity

`default_nettype wire
